// ===== common/rlb_pkg.sv
package rlb_pkg;

  // ---------------------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------------------
  localparam int RLB_PC_W = 16;
  localparam int RLB_DATA_W = 8;
  localparam int RLB_REG_SEL_W = 5;
  localparam int RLB_FLAG_W = 4;
  localparam int RLB_BANK_W = 2;
  // Stack word: pc, flags, irq enable, bank selections.
  localparam int RLB_STACK_W = RLB_PC_W + RLB_FLAG_W + 1 + RLB_BANK_W;

  // Instruction field positions.
  localparam int RLB_DISP_LSB = 0;
  localparam int RLB_RS_LSB = 0;
  localparam int RLB_POS_LSB = 4;
  localparam int RLB_STATE_BIT = 7;
  localparam int RLB_ROT_LSB = 4;
  localparam int RLB_MASK_LSB = 7;

  // Reset values.
  localparam logic [RLB_PC_W-1:0] RLB_PC_RESET = 16'h0000;

  // Operations that the decoder front end hands to this unit.
  typedef enum logic [2:0] {
    RLB_OP_NONE,
    RLB_OP_REL_IMM,
    RLB_OP_REL_REG,
    RLB_OP_TABLE,
    RLB_OP_CALL_COND,
    RLB_OP_CALL_ALWAYS
  } rlb_op_t;

endpackage

// ===== common/rlb_if.sv
`timescale 1ns/1ps
// Carries the register-file read request and the returned operand.
interface rlb_if;
  logic [4:0] sel;
  logic [7:0] data;
  modport ctrl (output sel, input data);
  modport file (input sel, output data);
endinterface

// ===== hdl/rlb_operand_shaper.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Operand shaping: rotate, mask and bit select, registered.
// -----------------------------------------------------------------------------
module rlb_operand_shaper
  import rlb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Operand and controls.
  input wire logic [7:0] src_in,
  input wire logic [2:0] rot_in,
  input wire logic [2:0] mask_in,
  input wire logic [2:0] pos_in,
  // Registered results.
  output logic [7:0] table_disp_out,
  output logic bit_out
);

  typedef struct packed {
    logic [7:0] disp;
    logic bit_val;
  } rlb_shape_t;

  rlb_shape_t state_reg;
  rlb_shape_t state_next;
  logic [15:0] doubled;
  logic [7:0] rotated;
  logic [7:0] keep;

  // Rotation by doubling the byte, so b of zero leaves the copy untouched.
  always_comb begin
    doubled = {src_in, src_in};
    rotated = doubled[rot_in +: 8];
    // Clear the top m bits and always the least significant bit.
    keep = (8'hff >> mask_in) & 8'hfe;
    state_next.disp = rotated & keep;
    state_next.bit_val = src_in[pos_in];
  end

  // Results are registered so the main unit sees stable operands.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign table_disp_out = state_reg.disp;
  assign bit_out = state_reg.bit_val;

  AST_LSB_ZERO: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    table_disp_out[0] == 1'b0) else $error("table displacement lsb not zero");

endmodule

// ===== hdl/rlb_branch_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Immediate jump adds sign-extended displacement to pc.
// - Register jump adds sign-extended register contents.
// - Relative reach is +127 to -128 words.
// - Base pc is the following instruction address.
// - Table jump rotates a copy right b places.
// - Then clears top m bits and lsb.
// - Table displacement lsb is always zero.
// - Sign extend, add; reach +126 to -128.
// - Source register may be any active register; table jumps and bit calls tie select bit 4 to bit 0 of b or p.
// - Call on bit match pushes full context.
// - Taken call loads the 16-bit absolute address.
// - Bit position selects bit 0 to 7.
// - Unconditional call always pushes and loads in the same cycle.
// -----------------------------------------------------------------------------
// Branch unit: relative jumps, table jump and long calls.
// -----------------------------------------------------------------------------
module rlb_branch_unit
  import rlb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Instruction request from the decoder.
  input wire logic start_in,
  input wire rlb_op_t op_in,
  input wire logic [7:0] low_byte_in,
  input wire logic [15:0] target_in,
  input wire logic [15:0] next_pc_in,
  // Context to be saved by calls.
  input wire logic [3:0] alu_flags_in,
  input wire logic global_irq_enable_bit_in,
  input wire logic [1:0] bank_sel_in,
  // Register file read port.
  output logic [4:0] src_sel_out,
  input wire logic [7:0] src_data_in,
  // Results.
  output logic pc_load_out,
  output logic [15:0] pc_out,
  output logic push_out,
  output logic [RLB_STACK_W-1:0] push_word_out,
  output logic busy_out,
  output logic done_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RLB_IDLE,
    RLB_FETCH,
    RLB_SHAPE,
    RLB_EXEC
  } rlb_fsm_t;

  typedef struct packed {
    rlb_fsm_t fsm;
    rlb_op_t op;
    logic [7:0] low;
    logic [15:0] target;
    logic [15:0] base;
    logic [RLB_STACK_W-1:0] ctx;
    logic [4:0] sel;
    logic pc_load;
    logic [15:0] pc;
    logic push;
    logic [RLB_STACK_W-1:0] push_word;
    logic done;
    logic busy;
  } rlb_state_t;

  // One registered copy of all state and its next value.
  rlb_state_t state_reg;
  rlb_state_t state_next;

  // Register operand travels through the interface to the shaper path.
  rlb_if rf ();
  logic [7:0] table_disp;
  logic tested_bit;

  assign rf.sel = state_reg.sel;
  assign rf.data = src_data_in;

  // Sign extension of an 8-bit displacement, used by every relative form.
  function automatic logic [15:0] rlb_sext(input logic [7:0] d);
    rlb_sext = {{8{d[7]}}, d};
  endfunction

  rlb_operand_shaper u_shaper (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .src_in(rf.data),
    .rot_in(state_reg.low[RLB_ROT_LSB +: 3]),
    .mask_in(state_reg.target[2:0]),
    .pos_in(state_reg.low[RLB_POS_LSB +: 3]),
    .table_disp_out(table_disp),
    .bit_out(tested_bit)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // The mask field m sits above the rotate field; the decoder passes m in
  // target_in[2:0] for table jumps so low_byte_in keeps b and source_reg.
  always_comb begin
    state_next = state_reg;
    state_next.pc_load = 1'b0;
    state_next.push = 1'b0;
    state_next.done = 1'b0;
    unique case (state_reg.fsm)
      RLB_IDLE: begin
        // Idle: latch the whole request so the inputs may move on at once.
        if (start_in && op_in != RLB_OP_NONE) begin
          state_next.op = op_in;
          state_next.low = low_byte_in;
          state_next.target = target_in;
          state_next.base = next_pc_in;
          // Context snapshot; stored only, never altered here.
          state_next.ctx = {next_pc_in, alu_flags_in, global_irq_enable_bit_in, bank_sel_in};
          // Limitation: the select shares bit 4 with the b and p fields.
          state_next.sel = low_byte_in[RLB_RS_LSB +: 5];
          // Immediate jumps and unconditional calls need no register read.
          if (op_in == RLB_OP_REL_IMM) begin
            state_next.fsm = RLB_EXEC;
          end else if (op_in == RLB_OP_CALL_ALWAYS) begin
            state_next.fsm = RLB_EXEC;
          end else begin
            state_next.fsm = RLB_FETCH;
          end
        end
      end
      RLB_FETCH: begin
        // One cycle for the register read, one for the shaper register.
        state_next.fsm = RLB_SHAPE;
      end
      RLB_SHAPE: begin
        // The shaper's registered result is valid from this cycle on.
        state_next.fsm = RLB_EXEC;
      end
      RLB_EXEC: begin
        // Every form ends here with exactly one done pulse.
        state_next.fsm = RLB_IDLE;
        state_next.done = 1'b1;
        unique case (state_reg.op)
          RLB_OP_REL_IMM: begin
            // The displacement is the immediate byte itself.
            state_next.pc_load = 1'b1;
            state_next.pc = state_reg.base + rlb_sext(state_reg.low);
          end
          RLB_OP_REL_REG: begin
            // The file still holds the register contents in this cycle.
            state_next.pc_load = 1'b1;
            state_next.pc = state_reg.base + rlb_sext(src_data_in);
          end
          RLB_OP_TABLE: begin
            // A rotated and masked copy; the register itself is untouched.
            state_next.pc_load = 1'b1;
            state_next.pc = state_reg.base + rlb_sext(table_disp);
          end
          RLB_OP_CALL_COND: begin
            // Match pushes and jumps; mismatch simply falls through.
            if (tested_bit == state_reg.low[RLB_STATE_BIT]) begin
              state_next.push = 1'b1;
              state_next.push_word = state_reg.ctx;
              state_next.pc_load = 1'b1;
              state_next.pc = state_reg.target;
            end
          end
          RLB_OP_CALL_ALWAYS: begin
            // Push and load together; the stack takes one whole word.
            state_next.push = 1'b1;
            state_next.push_word = state_reg.ctx;
            state_next.pc_load = 1'b1;
            state_next.pc = state_reg.target;
          end
          default: begin
            // Illegal codes do nothing but end the request.
            state_next.pc_load = 1'b0;
          end
        endcase
      end
    endcase
    // Busy is registered so the output leaves a flip-flop directly.
    state_next.busy = (state_next.fsm != RLB_IDLE);
  end

  // State register; synchronous reset returns to idle with nothing pending.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // Clear every field, then name the idle state and the reset pc outright.
      state_reg <= '0;
      state_reg.fsm <= RLB_IDLE;
      state_reg.op <= RLB_OP_NONE;
      state_reg.pc <= RLB_PC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign src_sel_out = state_reg.sel;
  assign pc_load_out = state_reg.pc_load;
  assign pc_out = state_reg.pc;
  assign push_out = state_reg.push;
  assign push_word_out = state_reg.push_word;
  // A request made while busy is dropped without a sign; callers wait for done.
  assign busy_out = state_reg.busy;
  assign done_out = state_reg.done;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Every check is cut off while reset is held.
  sequence s_imm_start;
    start_in && !busy_out && op_in == RLB_OP_REL_IMM;
  endsequence

  // Any request that the unit takes from idle.
  sequence s_taken;
    start_in && !busy_out && op_in != RLB_OP_NONE;
  endsequence

  // Requests that read the register file before they execute.
  sequence s_reg_start;
    start_in && !busy_out && op_in inside {RLB_OP_REL_REG, RLB_OP_TABLE, RLB_OP_CALL_COND};
  endsequence

  // Requests that carry every operand and execute at once.
  sequence s_short_start;
    start_in && !busy_out && op_in inside {RLB_OP_REL_IMM, RLB_OP_CALL_ALWAYS};
  endsequence

  // The steps of a short request: execute, then done.
  sequence s_short_walk;
    state_reg.fsm == RLB_EXEC ##1 done_out;
  endsequence

  // The steps of a register-operand request, one per cycle, ending in done.
  sequence s_reg_walk;
    state_reg.fsm == RLB_FETCH ##1 state_reg.fsm == RLB_SHAPE ##1 state_reg.fsm == RLB_EXEC ##1 done_out;
  endsequence

  // A conditional call in its execute cycle whose tested bit matches the state bit.
  sequence s_call_match;
    state_reg.fsm == RLB_EXEC && state_reg.op == RLB_OP_CALL_COND &&
      src_data_in[state_reg.low[RLB_POS_LSB +: 3]] == state_reg.low[RLB_STATE_BIT];
  endsequence

  // The same call whose tested bit differs; it must fall through.
  sequence s_call_miss;
    state_reg.fsm == RLB_EXEC && state_reg.op == RLB_OP_CALL_COND &&
      src_data_in[state_reg.low[RLB_POS_LSB +: 3]] != state_reg.low[RLB_STATE_BIT];
  endsequence

  AST_IMM_TARGET: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_imm_start |-> ##2 pc_load_out && pc_out == $past(next_pc_in, 2) + {{8{$past(low_byte_in[7], 2)}},
      $past(low_byte_in, 2)}) else $error("immediate jump target wrong");
  AST_REACH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pc_load_out && state_reg.op inside {RLB_OP_REL_IMM, RLB_OP_REL_REG} |->
      (16'(pc_out - state_reg.base + 16'h0080) <= 16'h00ff)) else $error("relative reach exceeded");
  AST_BASE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in && !busy_out && op_in != RLB_OP_NONE |=> state_reg.base == $past(next_pc_in))
    else $error("base pc not next instruction");
  AST_TABLE_EVEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pc_load_out && state_reg.op == RLB_OP_TABLE |-> pc_out[0] == state_reg.base[0])
    else $error("table jump offset odd");
  AST_CALL_PUSH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    push_out |-> pc_load_out && push_word_out == state_reg.ctx) else $error("push without load");
  AST_CALL_TARGET: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    push_out |-> pc_out == state_reg.target) else $error("call target wrong");
  AST_ALWAYS_CALL: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in && !busy_out && op_in == RLB_OP_CALL_ALWAYS |-> ##2 push_out) else $error("call did not push");
  AST_NO_PUSH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_call_miss |=> done_out && !push_out && !pc_load_out)
    else $error("untaken call pushed");
  AST_DONE_ONE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done_out |=> !done_out) else $error("done longer than one cycle");

  // Whole-request checks; the walk and call-match checks are built from the sequences above.
  AST_REG_WALK: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_reg_start |=> s_reg_walk) else $error("register request steps out of order");
  AST_SHORT_DONE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_short_start |=> s_short_walk) else $error("short request not done after two cycles");
  AST_REG_TARGET: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in && !busy_out && op_in == RLB_OP_REL_REG |-> ##4 pc_load_out &&
      pc_out == $past(next_pc_in, 4) + rlb_sext($past(src_data_in)))
    else $error("register jump target wrong");
  AST_CALL_TAKEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_call_match |=> push_out && pc_load_out && done_out) else $error("matching call did not push");
  AST_CTX_KEPT: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in && !busy_out && op_in == RLB_OP_CALL_ALWAYS |-> ##2
      push_word_out == $past({next_pc_in, alu_flags_in, global_irq_enable_bit_in, bank_sel_in}, 2))
    else $error("pushed context differs from the caller's");
  // A taken request must show busy and its source select a cycle later.
  AST_SEL: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_taken |=> busy_out && src_sel_out == $past(low_byte_in[RLB_RS_LSB +: 5])) else $error("source select wrong");
  AST_TABLE_REACH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in && !busy_out && op_in == RLB_OP_TABLE |-> ##4 pc_load_out &&
      16'(pc_out - $past(next_pc_in, 4) + 16'h0080) <= 16'h00fe) else $error("table jump reach exceeded");
  AST_LOAD_DONE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pc_load_out || push_out |-> done_out) else $error("load or push outside the final cycle");

endmodule

// ===== tb/rlb_regfile_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Register file model: the far side of the branch unit's operand read port.
// -----------------------------------------------------------------------------
module rlb_regfile_model (
  // Clock.
  input wire logic mclk_in,
  // Bench write port.
  input wire logic wr_en_in,
  input wire logic [4:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // Read port facing the branch unit.
  input wire logic [4:0] sel_in,
  output logic [7:0] data_out
);
  // All 32 selectable registers of the active banks.
  logic [7:0] mem_reg [32];

  // Start from zero so an early select never returns an unknown.
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem_reg[i] = 8'h00;
    end
  end

  // Writes land on the edge; the read is combinational, as the unit expects.
  always @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_sel_in] <= wr_data_in;
    end
  end

  // Any of the 32 registers may be named as the source.
  assign data_out = mem_reg[sel_in];
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  import rlb_pkg::*;
  // Clock, reset and stimulus.
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_in = 1'b0;
  rlb_op_t op_in = RLB_OP_NONE;
  logic [7:0] low_byte_in = 8'h00;
  logic [15:0] target_in = 16'h0000;
  logic [15:0] next_pc_in = 16'h0000;
  logic [3:0] alu_flags_in = 4'ha;
  logic global_irq_enable_bit_in = 1'b1;
  logic [1:0] bank_sel_in = 2'h2;
  logic wr_en = 1'b0;
  logic [4:0] wr_sel = 5'h00;
  logic [7:0] wr_data = 8'h00;
  // Design outputs and register file answer.
  logic [4:0] src_sel_out;
  logic [7:0] src_data_in;
  logic pc_load_out, push_out, busy_out, done_out;
  logic [15:0] pc_out;
  logic [RLB_STACK_W-1:0] push_word_out;
  int errors = 0;
  int n_checks = 0;

  // Half period of 50 ns gives the 10 MHz clock.
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  rlb_branch_unit u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in),
    .low_byte_in(low_byte_in), .target_in(target_in), .next_pc_in(next_pc_in), .alu_flags_in(alu_flags_in),
    .global_irq_enable_bit_in(global_irq_enable_bit_in), .bank_sel_in(bank_sel_in), .src_sel_out(src_sel_out),
    .src_data_in(src_data_in), .pc_load_out(pc_load_out), .pc_out(pc_out), .push_out(push_out),
    .push_word_out(push_word_out), .busy_out(busy_out), .done_out(done_out));

  rlb_regfile_model u_regs (.mclk_in(mclk_in), .wr_en_in(wr_en), .wr_sel_in(wr_sel), .wr_data_in(wr_data),
    .sel_in(src_sel_out), .data_out(src_data_in));

  // Prints the verdict and stops; the watchdog ends here too.
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Loads one register of the model, two edges before the next request.
  task automatic set_reg(input logic [4:0] idx, input logic [7:0] v);
    @(posedge mclk_in);
    wr_en <= 1'b1;
    wr_sel <= idx;
    wr_data <= v;
    @(posedge mclk_in);
    wr_en <= 1'b0;
  endtask

  // Issues one request and judges pulses, latency, target and pushed word.
  task automatic run_op(input rlb_op_t op, input logic [7:0] lb, input logic [15:0] tg, input logic ld,
                        input logic ps, input logic [15:0] epc);
    int k;
    int n_ld;
    int n_ps;
    k = 0;
    n_ld = 0;
    n_ps = 0;
    @(posedge mclk_in);
    start_in <= 1'b1;
    op_in <= op;
    low_byte_in <= lb;
    target_in <= tg;
    @(posedge mclk_in);
    start_in <= 1'b0;
    // Sample on the falling edge, where registered outputs have settled.
    @(negedge mclk_in);
    `CHK("busy while running", 1'b1, busy_out)
    while (done_out !== 1'b1 && k < 12) begin
      n_ld += int'(pc_load_out === 1'b1);
      n_ps += int'(push_out === 1'b1);
      @(negedge mclk_in);
      k++;
    end
    n_ld += int'(pc_load_out === 1'b1);
    n_ps += int'(push_out === 1'b1);
    `CHK("latency", (op == RLB_OP_REL_IMM || op == RLB_OP_CALL_ALWAYS) ? 1 : 3, k)
    `CHK("busy at done", 1'b0, busy_out)
    `CHK("source select", lb[4:0], src_sel_out)
    `CHK("pc loads", int'(ld), n_ld)
    `CHK("pushes", int'(ps), n_ps)
    if (ld) `CHK("pc", epc, pc_out)
    if (ps) `CHK("word", {next_pc_in, alu_flags_in, global_irq_enable_bit_in, bank_sel_in}, push_word_out)
  endtask

  // Immediate jumps at both ends of the reach, with pc wrap-around.
  task automatic t_rel_imm();
    @(posedge mclk_in);
    next_pc_in <= 16'hfff0;
    run_op(RLB_OP_REL_IMM, 8'h7f, 16'h0000, 1'b1, 1'b0, 16'h006f);
    run_op(RLB_OP_REL_IMM, 8'h80, 16'h0000, 1'b1, 1'b0, 16'hff70);
  endtask

  // Register displacements, including the highest register number.
  task automatic t_rel_reg();
    @(posedge mclk_in);
    next_pc_in <= 16'h1000;
    set_reg(5'h03, 8'h80);
    run_op(RLB_OP_REL_REG, 8'h03, 16'h0000, 1'b1, 1'b0, 16'h0f80);
    set_reg(5'h1f, 8'h7f);
    run_op(RLB_OP_REL_REG, 8'h1f, 16'h0000, 1'b1, 1'b0, 16'h107f);
  endtask

  // One table jump; the expected displacement is rotated and masked here.
  task automatic run_table(input logic [7:0] v, input logic [2:0] b, input logic [2:0] m);
    logic [7:0] lb;
    logic [7:0] d;
    lb = {1'b0, b, 4'h6};
    // Rotate one place at a time, then clear bit 0 and the top m bits.
    d = v;
    for (int r = 0; r < 8; r++) begin
      if (r < b) begin
        d = {d[0], d[7:1]};
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i > 7 - m) begin
        d[i] = 1'b0;
      end
    end
    set_reg(lb[4:0], v);
    run_op(RLB_OP_TABLE, lb, {13'h0000, m}, 1'b1, 1'b0, next_pc_in + {{8{d[7]}}, d});
  endtask

  // Every rotate and mask value, then the two ends of the reach.
  task automatic t_table();
    @(posedge mclk_in);
    next_pc_in <= 16'h4000;
    for (int b = 0; b < 8; b++) begin
      for (int m = 0; m < 8; m++) begin
        run_table(8'hb5, 3'(b), 3'(m));
      end
    end
    run_table(8'h7f, 3'h0, 3'h0);
    run_table(8'h81, 3'h0, 3'h0);
  endtask

  // Every bit position with both states; context varies per call.
  task automatic t_call_cond();
    logic [7:0] lb;
    logic hit;
    @(posedge mclk_in);
    next_pc_in <= 16'h2345;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 8; p++) begin
        lb = {1'(s), 3'(p), 4'hf};
        hit = (8'ha5 >> p) & 8'h01 ? (s == 1) : (s == 0);
        set_reg(lb[4:0], 8'ha5);
        // Context changes on the rising edge, well before the request is taken.
        alu_flags_in <= 4'(p) ^ 4'h9;
        global_irq_enable_bit_in <= 1'(p);
        bank_sel_in <= 2'(p >> 1);
        run_op(RLB_OP_CALL_COND, lb, 16'hc000 + 16'(p), hit, hit, 16'hc000 + 16'(p));
      end
    end
  endtask

  // Unconditional calls to the lowest and highest addresses.
  task automatic t_call_always();
    @(posedge mclk_in);
    next_pc_in <= 16'hffff;
    run_op(RLB_OP_CALL_ALWAYS, 8'h00, 16'h0000, 1'b1, 1'b1, 16'h0000);
    run_op(RLB_OP_CALL_ALWAYS, 8'h00, 16'hffff, 1'b1, 1'b1, 16'hffff);
  endtask

  // Main sequence: three cycles of reset, then every scenario.
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    `CHK("idle busy", 1'b0, busy_out)
    `CHK("reset pc", RLB_PC_RESET, pc_out)
    `CHK("reset strobes", 3'h0, {pc_load_out, push_out, done_out})
    t_rel_imm();
    t_rel_reg();
    t_table();
    t_call_cond();
    t_call_always();
    end_of_test();
  end

  // Watchdog: the run needs under a thousand cycles; allow five thousand.
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
endmodule
